// file: bench/elp_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module elp_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        an_success,
  input wire logic        rd_req,
  input wire logic        rd_mii,
  input wire logic [8:0]  rd_addr,
  input wire logic        rd_valid,
  input wire logic [31:0] rd_data
);
  logic rp;
  assign rp = rd_req && (rd_mii ? rd_addr[4:0] == 5'h05 : rd_addr == 9'h1d4);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rp;
    rp;
  endsequence
  property p_ans; rd_req |=> rd_valid && rd_data[31:16] == 16'h0; endproperty
  a_ans: assert property (p_ans) else $error("read answer late or wide");
  property p_np; s_rp |=> !rd_data[15]; endproperty
  a_np: assert property (p_np) else $error("next page set");
  property p_ack; s_rp |=> rd_data[14]; endproperty
  a_ack: assert property (p_ack) else $error("ack clear");
  property p_flt; s_rp |=> rd_data[13:12] == 2'h0; endproperty
  a_flt: assert property (p_flt) else $error("fault set");
  property p_t4; s_rp |=> !rd_data[9]; endproperty
  a_t4: assert property (p_t4) else $error("t4 set");
  property p_sel; s_rp |=> rd_data[4:0] == 5'h01; endproperty
  a_sel: assert property (p_sel) else $error("bad selector");
  property p_hot; s_rp ##0 an_success |=> $onehot(rd_data[8:5]); endproperty
  a_hot: assert property (p_hot) else $error("ability not one-hot");
  property p_an; s_rp ##0 !an_success |=> rd_data[8:5] == 4'h0; endproperty
  a_an: assert property (p_an) else $error("ability without autoneg");
endmodule : elp_chk
bind elp_partner_ability elp_chk u_chk (.clk(clk), .reset(reset), .an_success(an_success),
  .rd_req(rd_req), .rd_mii(rd_mii), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
`default_nettype wire

// file: bench/elp_mgmt_master.sv
`timescale 1ns/1ps
`default_nettype none
module elp_mgmt_master (
  // clock
  input  wire logic        clk,
  // requests
  output logic             rd_req,
  output logic             wr_req,
  output logic             mii,
  output logic [8:0]       addr,
  output logic [15:0]      wdata,
  // answer
  input  wire logic [31:0] rd_data
);
  initial
  begin
    {rd_req, wr_req, mii, addr, wdata} = '0;
  end
  task automatic rd(input logic m, input logic [8:0] a, output logic [31:0] d);
    @(posedge clk);
    #1 {rd_req, mii, addr} = {1'b1, m, a};
    @(posedge clk);
    #1 rd_req = 1'b0;
    d = rd_data;
  endtask : rd
  task automatic wr(input logic m, input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 {wr_req, mii, addr, wdata} = {1'b1, m, a, d};
    @(posedge clk);
    #1 wr_req = 1'b0;
  endtask : wr
endmodule : elp_mgmt_master
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import elp_pkg::*;
  logic        clk, reset, dpin, pol, spd, an, fc, rd_req, wr_req, mii, rd_valid;
  // partner symmetric pause per {adv asym, adv sym} from the pause table
  localparam logic [3:0] LP_SYM_TBL = 4'b0110;
  logic [8:0]  addr;
  logic [15:0] wdata;
  logic [31:0] rd_data, d;
  int          num_errors, n_tests, cyc, s, p, i;
  elp_partner_ability dut (.clk(clk), .reset(reset), .duplex_pin(dpin),
    .duplex_pol_strap(pol), .speed_strap(spd), .manual_fc_strap(fc), .an_success(an),
    .rd_req(rd_req), .rd_mii(mii), .rd_addr(addr), .rd_valid(rd_valid), .rd_data(rd_data),
    .wr_req(wr_req), .wr_mii(mii), .wr_addr(addr), .wr_data(wdata));
  elp_mgmt_master m (.clk(clk), .rd_req(rd_req), .wr_req(wr_req), .mii(mii), .addr(addr),
    .wdata(wdata), .rd_data(rd_data));
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  function automatic logic [31:0] pw(logic as, logic sy, logic [3:0] ab);
    return {16'h0, 4'b0100, as, sy, 1'b0, ab, ELP_SELECTOR_8023};
  endfunction : pw
  // straps flipped right after the latch edge to show they are held
  task automatic rst(input logic sv, input logic pv);
    {spd, pol, reset} = {sv, pv, 1'b1};
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    @(posedge clk);
    #1 {spd, pol, fc} = {~sv, ~pv, ~fc};
  endtask : rst
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      summarize();
    end
  end
  initial
  begin
    {reset, dpin, pol, spd, an, fc} = 6'h20;
    rst(0, 0);
    m.rd(1, 9'h005, d);
    check(d, pw(0, 1, ELP_ABIL_NONE));
    $display("no autoneg done");
    an = 1;
    for (s = 0; s < 4; s++)
    begin
      fc = s[1];
      rst(s[0], s[1]);
      for (p = 0; p < 2; p++)
      begin
        dpin = p[0];
        m.rd(0, ELP_OFF_PARTNER, d);
        check(d[8:5], (p[0] == s[1]) ? (s[0] ? ELP_ABIL_100_FULL : ELP_ABIL_10_FULL)
                        : (s[0] ? ELP_ABIL_100_HALF : ELP_ABIL_10_HALF));
      end
      m.rd(1, 9'h005, d);
      check(d[11:10], {1'b0, ~s[1]});
    end
    $display("duplex speed done");
    for (i = 0; i < 4; i++)
    begin
      m.wr(1, 9'h004, {4'h0, i[1], i[0], 10'h1e1});
      m.rd(1, 9'h005, d);
      check(d, pw(i[1], LP_SYM_TBL[i], ELP_ABIL_100_FULL));
    end
    $display("pause done");
    m.wr(0, ELP_OFF_PARTNER, 16'hffff);
    m.rd(0, ELP_OFF_PARTNER, d);
    check(d, pw(1, 0, ELP_ABIL_100_FULL));
    m.rd(0, 9'h1fc, d);
    check(d, 32'h0);
    $display("read only done");
    summarize();
  end
endmodule : testbench
`default_nettype wire

// file: logic/elp_compose.sv
`timescale 1ns/1ps
`default_nettype none
module elp_compose
  import elp_pkg::*;
(
  elp_src_if.composer src
);

  logic [3:0] abil;
  logic       lp_sym;
  logic       lp_asym;

  always_comb
  begin
    // partner sym is the xor of the advertised pause bits; partner asym copies adv_asym
    lp_sym  = src.adv_sym ^ src.adv_asym;
    lp_asym = src.adv_asym;
    if (!src.an_ok)
    begin
      abil = ELP_ABIL_NONE;
    end
    else if (src.duplex_match)
    begin
      abil = src.speed_100 ? ELP_ABIL_100_FULL : ELP_ABIL_10_FULL;
    end
    else
    begin
      abil = src.speed_100 ? ELP_ABIL_100_HALF : ELP_ABIL_10_HALF;
    end
  end

  always_comb
  begin
    src.word                            = 16'h0000;
    src.word[ELP_BIT_NEXT_PAGE]         = 1'b0;
    src.word[ELP_BIT_ACK]               = 1'b1;
    src.word[ELP_BIT_FAULT]             = 1'b0;
    src.word[ELP_BIT_ASYM]              = lp_asym;
    src.word[ELP_BIT_SYM]               = lp_sym;
    src.word[ELP_BIT_T4]                = 1'b0;
    src.word[ELP_ABIL_HI:ELP_ABIL_LO]   = abil;
    src.word[4:0]                       = ELP_SELECTOR_8023;
  end

endmodule : elp_compose
`default_nettype wire

// file: logic/elp_partner_ability.sv
// What this block does
// - partner ability register read-only at 1d4h; upper 16 bits zero, serial reads 16 bits
// - bit 15 next page always reads 0
// - bit 14 acknowledge always reads 1
// - bit 13 remote fault always 0; bit 12 reserved, read-only
// - bit 9 100BASE-T4 always reads 0
// - bits 4 to 0 read constant 00001b selector
// - partner pause bits 11 and 10 derive from advertised pause bits
// - no pause gives 0/0; symmetric only gives sym 1, asym 0
// - asymmetric only gives partner sym 1 and asym 1
// - both advertised gives partner sym 0 and asym 1
// - bits 8 to 5 one-hot once autoneg succeeds, else all zero: 100 full, 100 half, 10 full, 10 half
// - duplex pin equal to polarity strap reports full duplex, speed strap picks rate
// - duplex pin unequal to polarity strap reports half duplex
// - straps latched at reset release; ability also depends on autoneg success
// - advertisement bits 11 and 10 are writable and feed partner pause bits
`timescale 1ns/1ps
`default_nettype none
module elp_partner_ability
  import elp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // pins and straps
  input  wire logic        duplex_pin,
  input  wire logic        duplex_pol_strap,
  input  wire logic        speed_strap,
  input  wire logic        manual_fc_strap,
  input  wire logic        an_success,
  // register read port
  input  wire logic        rd_req,
  input  wire logic        rd_mii,
  input  wire logic [8:0]  rd_addr,
  output logic             rd_valid,
  output logic [31:0]      rd_data,
  // register write port
  input  wire logic        wr_req,
  input  wire logic        wr_mii,
  input  wire logic [8:0]  wr_addr,
  input  wire logic [15:0] wr_data
);

  elp_src_if src ();

  logic       reset_q_ff;
  logic       dup_pol_ff;
  logic       speed_ff;
  logic       adv_asym_ff;
  logic       adv_sym_ff;
  logic [3:0] adv_abil_ff;
  logic       rd_valid_ff;
  logic [31:0] rd_data_ff;
  logic [15:0] adv_word;
  logic       wr_adv;
  logic       rd_adv;
  logic       rd_partner;
  logic [31:0] nxt_rd_data;

  elp_compose u_compose
  (
    .src (src)
  );

  // straps are sampled on the cycle reset falls, not while it is held
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reset_q_ff <= 1'b1;
    end
    else
    begin
      reset_q_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dup_pol_ff <= 1'b0;
      speed_ff   <= 1'b0;
    end
    else if (reset_q_ff)
    begin
      dup_pol_ff <= duplex_pol_strap;
      speed_ff   <= speed_strap;
    end
  end

  // a write on the strap latch edge is dropped so the strap default wins
  always_comb
  begin
    wr_adv = 1'b0;
    if (wr_req && !reset_q_ff && wr_mii && wr_addr[4:0] == ELP_IDX_ADV)
    begin
      wr_adv = 1'b1;
    end
    else if (wr_req && !reset_q_ff && !wr_mii && wr_addr == ELP_OFF_ADV)
    begin
      wr_adv = 1'b1;
    end
  end

  always_comb
  begin
    rd_adv     = 1'b0;
    rd_partner = 1'b0;
    if (rd_mii && rd_addr[4:0] == ELP_IDX_ADV)
    begin
      rd_adv = 1'b1;
    end
    else if (rd_mii && rd_addr[4:0] == ELP_IDX_PARTNER)
    begin
      rd_partner = 1'b1;
    end
    else if (!rd_mii && rd_addr == ELP_OFF_ADV)
    begin
      rd_adv = 1'b1;
    end
    else if (!rd_mii && rd_addr == ELP_OFF_PARTNER)
    begin
      rd_partner = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      adv_asym_ff <= ELP_RST_ADV_ASYM;
    end
    else if (wr_adv)
    begin
      adv_asym_ff <= wr_data[ELP_BIT_ASYM];
    end
  end

  // symmetric pause default is the inverse of the manual flow control strap at release
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      adv_sym_ff <= 1'b0;
    end
    else if (reset_q_ff)
    begin
      adv_sym_ff <= ~manual_fc_strap;
    end
    else if (wr_adv)
    begin
      adv_sym_ff <= wr_data[ELP_BIT_SYM];
    end
  end

  // ability bits are kept for readback only; the partner word ignores them
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      adv_abil_ff <= ELP_RST_ADV_ABIL;
    end
    else if (wr_adv)
    begin
      adv_abil_ff <= wr_data[ELP_ABIL_HI:ELP_ABIL_LO];
    end
  end

  always_comb
  begin
    src.adv_asym     = adv_asym_ff;
    src.adv_sym      = adv_sym_ff;
    src.duplex_match = (duplex_pin == dup_pol_ff);
    src.speed_100    = speed_ff;
    src.an_ok        = an_success;
  end

  always_comb
  begin
    adv_word                          = 16'h0000;
    adv_word[ELP_BIT_ASYM]            = adv_asym_ff;
    adv_word[ELP_BIT_SYM]             = adv_sym_ff;
    adv_word[ELP_ABIL_HI:ELP_ABIL_LO] = adv_abil_ff;
    adv_word[4:0]                     = ELP_SELECTOR_8023;
  end

  // partner word is live, so a read right after a pause rewrite sees it
  always_comb
  begin
    nxt_rd_data = 32'h0000_0000;
    if (rd_partner)
    begin
      nxt_rd_data = {16'h0000, src.word};
    end
    else if (rd_adv)
    begin
      nxt_rd_data = {16'h0000, adv_word};
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= rd_req;
    end
  end

  // data is held between reads so a slow master may still pick it up late
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_data_ff <= 32'h0000_0000;
    end
    else if (rd_req)
    begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_valid = rd_valid_ff;
  assign rd_data  = rd_data_ff;

endmodule : elp_partner_ability
`default_nettype wire

// file: logic/elp_pkg.sv
`default_nettype none
package elp_pkg;
  // register map byte offsets and serial management indexes
  localparam logic [8:0] ELP_OFF_ADV      = 9'h1d0;
  localparam logic [8:0] ELP_OFF_PARTNER  = 9'h1d4;
  localparam logic [4:0] ELP_IDX_ADV      = 5'h04;
  localparam logic [4:0] ELP_IDX_PARTNER  = 5'h05;
  // ability word field positions
  localparam int ELP_BIT_NEXT_PAGE = 15;
  localparam int ELP_BIT_ACK       = 14;
  localparam int ELP_BIT_FAULT     = 13;
  localparam int ELP_BIT_ASYM      = 11;
  localparam int ELP_BIT_SYM       = 10;
  localparam int ELP_BIT_T4        = 9;
  localparam int ELP_ABIL_HI       = 8;
  localparam int ELP_ABIL_LO       = 5;
  // fixed values
  localparam logic [4:0] ELP_SELECTOR_8023 = 5'h01;
  localparam logic [3:0] ELP_ABIL_100_FULL = 4'h8;
  localparam logic [3:0] ELP_ABIL_100_HALF = 4'h4;
  localparam logic [3:0] ELP_ABIL_10_FULL  = 4'h2;
  localparam logic [3:0] ELP_ABIL_10_HALF  = 4'h1;
  localparam logic [3:0] ELP_ABIL_NONE     = 4'h0;
  // reset values of the advertisement word
  localparam logic       ELP_RST_ADV_ASYM  = 1'b0;
  localparam logic [3:0] ELP_RST_ADV_ABIL  = 4'hf;
endpackage : elp_pkg
`default_nettype wire

// file: logic/elp_src_if.sv
`timescale 1ns/1ps
`default_nettype none
interface elp_src_if;
  logic        adv_asym;
  logic        adv_sym;
  logic        duplex_match;
  logic        speed_100;
  logic        an_ok;
  logic [15:0] word;
  modport owner    (output adv_asym, adv_sym, duplex_match, speed_100, an_ok, input word);
  modport composer (input adv_asym, adv_sym, duplex_match, speed_100, an_ok, output word);
endinterface : elp_src_if
`default_nettype wire
